// [logic/iqt_map.vh]
// iqt_map.vh: offsets, field positions and reset values of the queue tracker
// assumes: included by bare name from the tracker design files
`ifndef IQT_MAP_VH
`define IQT_MAP_VH

// register byte offsets on the bus
`define IQT_CTRL_OFS        12'h000
`define IQT_STAT_OFS        12'h004
// control register fields
`define IQT_CTRL_NARROW     0
`define IQT_CTRL_SOFTCLR    1
`define IQT_CTRL_STICKYCLR  2
`define IQT_CTRL_RST        3'h0
// status register fields
`define IQT_STAT_LEVEL_LSB  0
`define IQT_STAT_ILLEGAL    3
`define IQT_STAT_ILLSTICKY  4
`define IQT_STAT_LAST       5
`define IQT_STAT_PREV       6
`define IQT_STAT_FILL       7
// queue status encodings {bit1, bit0}
`define IQT_QS_NOOP         2'h0
`define IQT_QS_FIRST        2'h1
`define IQT_QS_FLUSH        2'h2
`define IQT_QS_NEXT         2'h3
// illegal queue levels and the reset level
`define IQT_LVL_ILL_ALL     3'h7
`define IQT_LVL_ILL_NAR5    3'h5
`define IQT_LVL_ILL_NAR6    3'h6
`define IQT_LVL_RST         3'h0
// AHB transfer type
`define IQT_HTRANS_NONSEQ   2'h2

`endif

// [logic/iqt_level_adder.v]
// iqt_level_adder.v: 3-bit queue level adder with weighted increment lines
// assumes: increment lines are decoded elsewhere; carry-in tied to the five line
`timescale 1ns/100ps
`default_nettype none

module iqt_level_adder (
   input  wire [2:0] levelIn,     // current tracked level
   input  wire       incOne,      // add one
   input  wire       incTwo,      // add two
   input  wire       incFive,     // add four plus carry-in
   output wire [2:0] levelOut     // wrapped sum
);

   // operand: bit2 from the five line, bit1 from two, bit0 from one
   wire [2:0] operand;
   wire [3:0] sum;

   assign operand = {incFive, incTwo, incOne};
   // carry-in also from the five line, so five plus two gives seven
   assign sum = {1'b0, levelIn} + {1'b0, operand} + {3'h0, incFive};
   assign levelOut = sum[2:0];   // drop carry: wraps modulo eight [R05]

endmodule // iqt_level_adder

`default_nettype wire

// [logic/iqt_queue_tracker.v]
// iqt_queue_tracker.v: passive prefetch queue tracker with AHB-Lite status port
// assumes: processor status inputs are synchronous to core_clk, one cycle per
// processor clock; a single AHB-Lite master, single word transfers
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "iqt_map.vh"

// Function
// (R01) upper byte fill, no-op: increment one
// (R02) lower byte fill, none removed: increment one
// (R03) word fill, none executed: increment two
// (R04) byte out, no fill: five with two
// (R05) three bit adder wraps modulo eight
// (R06) level register loads sum, inverted outputs
// (R07) queue clear zeroes level, resume next
// (R08) level seven illegal; five, six narrow
// (R09) each removal: first, subsequent, or flush
// (R10) first byte strobe, registered delayed copy
// (R11) decrement strobe clocks history register
// (R12) delayed first bit into last stage
// (R13) last stage shifts into previous stage
// (R14) queue clear resets both history stages
// (R15) results pass two delay flip-flops
// (R16) fill decode on both polarity outputs
// (R17) non-fetch: line2 low, memory, read
// (R18) flush status produces active-low clear
// (R19) word fill with one out: one
// (R20) fetch: lines show last, previous first
// (R21) no movement: no increment, level holds
// (R22) reset clears level and history
module iqt_queue_tracker (
   input  wire        core_clk,              // processor clock
   input  wire        rstn,                  // async reset, active low
   input  wire        queue_status_bit0,     // queue status bit 0
   input  wire        queue_status_bit1,     // queue status bit 1
   input  wire        bus_status_bit0,       // bus status bit 0
   input  wire        bus_status_bit1,       // bus status bit 1
   input  wire        bus_status_bit2,       // bus status bit 2
   input  wire        first_bus_state,       // high in first bus state
   input  wire        addrBit0,              // address bit 0
   input  wire        highByteEnableN,       // high byte enable, active low
   input  wire        memNotIo,              // 1 memory, 0 I/O cycle
   input  wire        readNotWrite,          // 1 read, 0 write
   output reg         queue_fill_event,      // code fetch, active high
   output reg         queueFillN,            // code fetch, active low
   output reg         queue_clear_n,         // queue flush pulse, active low
   output reg  [2:0]  levelOutN,             // inverted tracked level
   output reg         last_byte_first_n,     // last byte began instruction
   output reg         prev_byte_first_n,     // second-to-last began one
   output reg         analyzer_ctrl_line0,   // read/write or last-was-first
   output reg         analyzer_ctrl_line1,   // mem/io or second-last-first
   output reg         analyzer_ctrl_line2,   // code fetch indication
   input  wire        hsel,                  // AHB slave select
   input  wire [11:0] haddr,                 // AHB address
   input  wire [1:0]  htrans,                // AHB transfer type
   input  wire        hwrite,                // AHB write
   input  wire [2:0]  hsize,                 // AHB size, word only
   input  wire [31:0] hwdata,                // AHB write data
   input  wire        hready,                // AHB bus ready
   output reg         hreadyout,             // AHB slave ready
   output reg         hresp,                 // AHB response, always OKAY
   output reg  [31:0] hrdata                 // AHB read data
);

   // decoded queue status and byte selection
   wire [1:0] qs;
   wire       qsNoop;
   wire       qsFlush;
   wire       byteRemoved;
   wire       wordSel;
   wire       upperSel;
   wire       lowerSel;
   wire       fillNow;

   // increment lines and adder
   wire       inc_one_line;
   wire       inc_two_line;
   wire       inc_five_line;
   wire       inc_two_intermediate;
   wire [2:0] levelSum;

   // state
   reg  [2:0] level_register_bits_q;
   reg        first_byte_strobe_delayed_q;
   reg        removedDly_q;
   reg        lastStage_q;
   reg        prevStage_q;
   reg        illegalSticky_q;
   reg  [2:0] ctrl_q;
   reg        softClr_q;
   reg        dlyFill_q;
   reg  [2:0] dlyLevel_q;
   reg        dlyLast_q;
   reg        dlyPrev_q;

   // bus phase capture
   reg        busWr_q;
   reg  [11:0] busAddr_q;

   wire       first_byte_strobe;
   wire       queue_decrement_strobe;
   wire       queueClearAll;
   wire       illegalNow;
   wire       busTake;
   wire [31:0] statusWord;
   reg  [31:0] readMux;

   // queue status classification: no-op, first, flush, subsequent
   assign qs          = {queue_status_bit1, queue_status_bit0};
   assign qsNoop      = (qs == `IQT_QS_NOOP);
   assign qsFlush     = (qs == `IQT_QS_FLUSH);                 // [R09] [R18]
   assign byteRemoved = queue_status_bit0;                     // [R09]
   assign first_byte_strobe = (qs == `IQT_QS_FIRST);           // [R09] [R10]

   // byte selection during a fill
   assign wordSel  = ~highByteEnableN & ~addrBit0;
   assign upperSel = addrBit0;
   assign lowerSel = highByteEnableN & ~addrBit0;

   // code fetch decode in first bus state
   assign fillNow = first_bus_state & ~bus_status_bit0 & ~bus_status_bit1
                    & bus_status_bit2;                         // [R16]

   // count decoder
   assign inc_one_line = (fillNow & upperSel & qsNoop)         // [R01]
                       | (fillNow & lowerSel & qsNoop)         // [R02]
                       | (fillNow & wordSel & byteRemoved);    // [R19]
   assign inc_two_intermediate = byteRemoved & ~fillNow;
   assign inc_two_line = (fillNow & wordSel & qsNoop)          // [R03]
                       | inc_two_intermediate;                 // [R04]
   assign inc_five_line = inc_two_intermediate;  // never alone [R04]
   // no byte in or out leaves all lines low, so the sum is the level [R21]

   iqt_level_adder levelAdder (
      .levelIn  (level_register_bits_q),
      .incOne   (inc_one_line),
      .incTwo   (inc_two_line),
      .incFive  (inc_five_line),
      .levelOut (levelSum)
   );

   // flush, soft clear from software; reset handled by rstn [R22]
   assign queueClearAll = qsFlush | softClr_q;

   // illegal level check for both variants
   assign illegalNow = (level_register_bits_q == `IQT_LVL_ILL_ALL)
                     | (ctrl_q[`IQT_CTRL_NARROW]
                        & ((level_register_bits_q == `IQT_LVL_ILL_NAR5)
                        | (level_register_bits_q == `IQT_LVL_ILL_NAR6))); // [R08]

   // decrement strobe from the delayed removal state
   assign queue_decrement_strobe = removedDly_q;               // [R11]

   // level register: clear wins, else load the adder result
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         level_register_bits_q <= `IQT_LVL_RST;                // [R22]
      end else if (queueClearAll) begin
         level_register_bits_q <= `IQT_LVL_RST;                // [R07]
      end else begin
         level_register_bits_q <= levelSum;                    // [R06]
      end
   end

   // first-byte strobe delay and removal delay
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         first_byte_strobe_delayed_q <= 1'b0;
         removedDly_q                <= 1'b0;
      end else begin
         first_byte_strobe_delayed_q <= first_byte_strobe;     // [R10]
         removedDly_q                <= byteRemoved;           // [R11]
      end
   end

   // first-byte history shift register
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lastStage_q <= 1'b0;                                  // [R22]
         prevStage_q <= 1'b0;
      end else if (queueClearAll) begin
         lastStage_q <= 1'b0;                                  // [R14]
         prevStage_q <= 1'b0;
      end else if (queue_decrement_strobe) begin
         lastStage_q <= first_byte_strobe_delayed_q;           // [R12]
         prevStage_q <= lastStage_q;                           // [R13]
      end
   end

   // first delay stage aligning results with the bus cycle
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dlyFill_q  <= 1'b0;
         dlyLevel_q <= `IQT_LVL_RST;
         dlyLast_q  <= 1'b0;
         dlyPrev_q  <= 1'b0;
      end else begin
         dlyFill_q  <= fillNow;
         dlyLevel_q <= level_register_bits_q;                  // [R15]
         dlyLast_q  <= lastStage_q;                            // [R15]
         dlyPrev_q  <= prevStage_q;
      end
   end

   // analyzer outputs: second delay stage for level, history, control line 2 and fetch-time lines 0/1; fill, clear and non-fetch lines 0/1 registered once
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         queue_fill_event    <= 1'b0;
         queueFillN          <= 1'b1;
         queue_clear_n       <= 1'b1;
         levelOutN           <= ~`IQT_LVL_RST;
         last_byte_first_n   <= 1'b1;
         prev_byte_first_n   <= 1'b1;
         analyzer_ctrl_line0 <= 1'b0;
         analyzer_ctrl_line1 <= 1'b0;
         analyzer_ctrl_line2 <= 1'b0;
      end else begin
         queue_fill_event    <= fillNow;                       // [R16]
         queueFillN          <= ~fillNow;                      // [R16]
         queue_clear_n       <= ~qsFlush;                      // [R18]
         levelOutN           <= ~dlyLevel_q;                   // [R06] [R15]
         last_byte_first_n   <= ~dlyLast_q;                    // [R12]
         prev_byte_first_n   <= ~dlyPrev_q;                    // [R13]
         analyzer_ctrl_line2 <= dlyFill_q;                     // [R17]
         if (dlyFill_q) begin
            analyzer_ctrl_line0 <= dlyLast_q;                  // [R20]
            analyzer_ctrl_line1 <= dlyPrev_q;                  // [R20]
         end else begin
            analyzer_ctrl_line0 <= readNotWrite;               // [R17]
            analyzer_ctrl_line1 <= memNotIo;                   // [R17]
         end
      end
   end

   // sticky illegal flag: set wins over software clear
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         illegalSticky_q <= 1'b0;
      end else if (illegalNow) begin
         illegalSticky_q <= 1'b1;                              // [R08]
      end else if (busWr_q && (busAddr_q == `IQT_CTRL_OFS)
                   && hwdata[`IQT_CTRL_STICKYCLR]) begin
         illegalSticky_q <= 1'b0;
      end
   end

   // status word seen by software
   assign statusWord = {24'h00_0000,
                        fillNow,
                        prevStage_q,
                        lastStage_q,
                        illegalSticky_q,
                        illegalNow,
                        level_register_bits_q};

   // address phase taken when selected, non-sequential and bus ready
   assign busTake = hsel & hready & (htrans == `IQT_HTRANS_NONSEQ);

   // read mux for address decode
   always @* begin
      readMux = 32'h0000_0000;
      if (haddr == `IQT_CTRL_OFS) begin
         readMux = {29'h0000_0000, 1'b0, 1'b0, ctrl_q[`IQT_CTRL_NARROW]};
      end else if (haddr == `IQT_STAT_OFS) begin
         readMux = statusWord;
      end else begin
         readMux = 32'h0000_0000;    // unmapped reads zero
      end
   end

   // AHB-Lite slave: zero wait, read data captured at the address phase
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busWr_q   <= 1'b0;
         busAddr_q <= 12'h000;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (hready) begin
            busWr_q   <= busTake & hwrite;
            busAddr_q <= haddr;
            if (busTake && !hwrite) begin
               hrdata <= readMux;
            end
         end
      end
   end

   // control register write in the data phase; soft clear is a pulse
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q    <= `IQT_CTRL_RST;
         softClr_q <= 1'b0;
      end else begin
         softClr_q <= 1'b0;
         if (busWr_q && (busAddr_q == `IQT_CTRL_OFS)) begin
            ctrl_q[`IQT_CTRL_NARROW] <= hwdata[`IQT_CTRL_NARROW];
            softClr_q                <= hwdata[`IQT_CTRL_SOFTCLR];
         end
      end
   end

endmodule // iqt_queue_tracker

`default_nettype wire

// [tb/iqt_queue_tracker_properties.sv]
// iqt_queue_tracker_properties.sv: port-level checks of the queue tracker
// assumes: bound to iqt_queue_tracker, one clock domain, reset active low
`timescale 1ns/100ps
`default_nettype none
module iqt_queue_tracker_properties (
   input wire logic       core_clk,            // processor clock
   input wire logic       rstn,                // reset, active low
   input wire logic       queue_status_bit0,   // queue status bit 0
   input wire logic       queue_status_bit1,   // queue status bit 1
   input wire logic       bus_status_bit0,     // bus status bit 0
   input wire logic       bus_status_bit1,     // bus status bit 1
   input wire logic       bus_status_bit2,     // bus status bit 2
   input wire logic       first_bus_state,     // first bus state
   input wire logic       hsel,                // bus select
   input wire logic [1:0] htrans,              // transfer type
   input wire logic       hwrite,              // bus write
   input wire logic       hreadyout,           // slave ready
   input wire logic       hresp,               // slave response
   input wire logic       queue_fill_event,    // fill, active high
   input wire logic       queueFillN,          // fill, active low
   input wire logic       queue_clear_n,       // clear pulse
   input wire logic [2:0] levelOutN,           // inverted level
   input wire logic       last_byte_first_n,   // last byte began one
   input wire logic       prev_byte_first_n,   // previous byte began one
   input wire logic       analyzer_ctrl_line0, // control line 0
   input wire logic       analyzer_ctrl_line2  // control line 2
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   logic       fillIn;
   logic       flushIn;
   logic       quietIn;
   logic [3:0] quietCnt_q;
   // decode what the tracker sees at its inputs
   assign fillIn  = first_bus_state & ~bus_status_bit0 & ~bus_status_bit1 & bus_status_bit2;
   assign flushIn = queue_status_bit1 & ~queue_status_bit0;
   assign quietIn = ~queue_status_bit0 & ~queue_status_bit1 & ~fillIn & ~(hsel & htrans[1] & hwrite);
   // saturating count of cycles with no queue movement and no bus write
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         quietCnt_q <= 4'h0;
      else if (!quietIn)
         quietCnt_q <= 4'h0;
      else if (quietCnt_q != 4'hf)
         quietCnt_q <= quietCnt_q + 4'h1;
   end
   a_fill_polarity: assert property (queue_fill_event != queueFillN)
      else $error("fill outputs not complementary");
   a_fill_decode: assert property (queue_fill_event == $past(fillIn))
      else $error("fill decode wrong");
   a_line2_aligned: assert property (analyzer_ctrl_line2 == $past(queue_fill_event))
      else $error("control line 2 misaligned with fill");
   a_clear_pulse: assert property (queue_clear_n == !$past(flushIn))
      else $error("clear pulse wrong");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   a_quiet_level: assert property (quietCnt_q >= 4'h7 |-> $stable(levelOutN))
      else $error("level moved with no queue movement");
   a_quiet_history: assert property (quietCnt_q >= 4'h7 |-> $stable({last_byte_first_n, prev_byte_first_n}))
      else $error("history moved with no removal");
   a_flush_zero: assert property (flushIn ##1 quietIn[*5] |=> levelOutN == 3'h7 && last_byte_first_n && prev_byte_first_n)
      else $error("flush did not clear level and history");
   c_flush: cover property (flushIn ##1 quietIn[*5]);
   c_fetch_hist: cover property (analyzer_ctrl_line2 && analyzer_ctrl_line0);
   c_decrement: cover property (queue_status_bit0 && !fillIn);
endmodule // iqt_queue_tracker_properties
bind iqt_queue_tracker iqt_queue_tracker_properties u_props (
   .core_clk(core_clk), .rstn(rstn), .queue_status_bit0(queue_status_bit0),
   .queue_status_bit1(queue_status_bit1), .bus_status_bit0(bus_status_bit0),
   .bus_status_bit1(bus_status_bit1), .bus_status_bit2(bus_status_bit2),
   .first_bus_state(first_bus_state), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hreadyout(hreadyout), .hresp(hresp), .queue_fill_event(queue_fill_event),
   .queueFillN(queueFillN), .queue_clear_n(queue_clear_n), .levelOutN(levelOutN),
   .last_byte_first_n(last_byte_first_n), .prev_byte_first_n(prev_byte_first_n),
   .analyzer_ctrl_line0(analyzer_ctrl_line0), .analyzer_ctrl_line2(analyzer_ctrl_line2)
);
`default_nettype wire

// [tb/iqt_cpu_model.sv]
// iqt_cpu_model.sv: behavioural processor pins seen by the queue tracker
// assumes: commands change just after core_clk rising edges
`timescale 1ns/100ps
`default_nettype none
module iqt_cpu_model (
   input  wire logic       core_clk, // processor clock
   input  wire logic       rstn,     // reset, active low
   input  wire logic [1:0] fillKind, // 0 none, 1 lower, 2 upper, 3 word
   input  wire logic [1:0] qsCmd,    // queue status to present
   input  wire logic       rnwCmd,   // read, not write
   input  wire logic       mnioCmd,  // memory, not i/o
   input  wire logic [7:0] noise,    // filler for don't-care pins
   output var  logic [1:0] cpuQs,    // queue status {bit1, bit0}
   output var  logic       cpuT1,    // first bus state
   output var  logic [2:0] cpuBus,   // bus status {bit2, bit1, bit0}
   output var  logic       cpuA0,    // address bit 0
   output var  logic       cpuHbeN,  // high byte enable, active low
   output var  logic       cpuRnw,   // read, not write
   output var  logic       cpuMnio   // memory, not i/o
);
   logic [3:0] idleSt;
   // any bus state but a code fetch, so idle cycles never count
   assign idleSt = (noise[3:0] == 4'hc) ? 4'h4 : noise[3:0];
   // present one processor clock of status per edge
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn)
         {cpuQs, cpuT1, cpuBus, cpuA0, cpuHbeN, cpuRnw, cpuMnio} <= '0;
      else if (fillKind == 2'h0)
         {cpuQs, cpuT1, cpuBus, cpuA0, cpuHbeN, cpuRnw, cpuMnio} <=
            {qsCmd, idleSt, noise[5:4], rnwCmd, mnioCmd};
      else
         {cpuQs, cpuT1, cpuBus, cpuA0, cpuHbeN, cpuRnw, cpuMnio} <= {qsCmd, 4'hc,
            fillKind == 2'h2, fillKind == 2'h1 || (fillKind == 2'h2 && noise[6]), rnwCmd, mnioCmd};
   end
endmodule // iqt_cpu_model
`default_nettype wire

// [tb/iqt_testbench.sv]
// iqt_testbench.sv: random queue traffic with a level and history model
// assumes: the tracker and the processor model share core_clk at 250 MHz
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic core_clk, rstn, rnwCmd, mnioCmd, hsel, hwrite, queue_fill_event, queueFillN;
   logic queue_clear_n, last_byte_first_n, prev_byte_first_n, hreadyout, hresp;
   logic analyzer_ctrl_line0, analyzer_ctrl_line1, analyzer_ctrl_line2;
   logic cpuT1, cpuA0, cpuHbeN, cpuRnw, cpuMnio;
   logic [1:0] fillKind, qsCmd, htrans, cpuQs;
   logic [2:0] cpuBus, hsize, levelOutN, expLvl;
   logic [7:0] noise;
   logic [11:0] haddr;
   logic [31:0] hwdata, hrdata;
   logic expLast, expPrev, expSticky, narrow;
   integer seed = 53241;
   int miscompares = 0;
   int check_count = 0;
   iqt_cpu_model i_cpu (.core_clk(core_clk), .rstn(rstn), .fillKind(fillKind), .qsCmd(qsCmd),
      .rnwCmd(rnwCmd), .mnioCmd(mnioCmd), .noise(noise), .cpuQs(cpuQs), .cpuT1(cpuT1),
      .cpuBus(cpuBus), .cpuA0(cpuA0), .cpuHbeN(cpuHbeN), .cpuRnw(cpuRnw), .cpuMnio(cpuMnio));
   iqt_queue_tracker i_dut (.core_clk(core_clk), .rstn(rstn), .queue_status_bit0(cpuQs[0]),
      .queue_status_bit1(cpuQs[1]), .bus_status_bit0(cpuBus[0]), .bus_status_bit1(cpuBus[1]),
      .bus_status_bit2(cpuBus[2]), .first_bus_state(cpuT1), .addrBit0(cpuA0),
      .highByteEnableN(cpuHbeN), .memNotIo(cpuMnio), .readNotWrite(cpuRnw),
      .queue_fill_event(queue_fill_event), .queueFillN(queueFillN),
      .queue_clear_n(queue_clear_n), .levelOutN(levelOutN),
      .last_byte_first_n(last_byte_first_n), .prev_byte_first_n(prev_byte_first_n),
      .analyzer_ctrl_line0(analyzer_ctrl_line0), .analyzer_ctrl_line1(analyzer_ctrl_line1),
      .analyzer_ctrl_line2(analyzer_ctrl_line2), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   // free-running processor clock
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   function automatic logic ill(input logic [2:0] l, input logic n);
      return l == 3'h7 || (n && (l == 3'h5 || l == 3'h6));
   endfunction
   function automatic logic [2:0] bytesIn(input logic [1:0] k);
      return (k == 2'h3) ? 3'h2 : {2'h0, k != 2'h0};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         miscompares++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
      end
   endtask
   // one processor clock of traffic, mirrored in the reference model
   task automatic op(input logic [1:0] k, input logic [1:0] q);
      fillKind <= k;
      qsCmd <= q;
      noise <= 8'($random(seed));
      @(posedge core_clk);
      if (q == 2'h2)
         {expLvl, expLast, expPrev} = 5'h0;
      else
         expLvl = expLvl + bytesIn(k) - {2'h0, q[0]};
      if (q[0])
         {expPrev, expLast} = {expLast, ~q[1]};
      expSticky |= ill(expLvl, narrow);
   endtask
   // single AHB-Lite word transfer, address phase then data phase
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic close_out();
      if (miscompares == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // main sequence: random bursts, a fetch window, then a quiet check
   initial begin
      int s;
      int i;
      logic [31:0] v;
      logic [31:0] w;
      logic [31:0] rd;
      {rstn, hsel, hwrite, rnwCmd, mnioCmd, fillKind, qsCmd, htrans} <= '0;
      {noise, haddr, hsize, hwdata} <= '0;
      {expLvl, expLast, expPrev, expSticky, narrow} = '0;
      repeat (16) @(posedge core_clk);
      rstn <= 1'b1;
      ahb(1'b1, 12'h008, 32'hffff_ffff, rd);
      ahb(1'b0, 12'h008, 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
      for (s = 0; s < 60; s++) begin
         v = $random(seed);
         rnwCmd <= v[0];
         mnioCmd <= v[1];
         if (v[4]) begin
            // a sticky clear loses to a level still illegal under the old width
            if (v[6] & ~v[7])
               expSticky = ill(expLvl, narrow);
            narrow = v[7] ? narrow : v[5];
            ahb(1'b1, 12'h000, {29'h0, v[6] & ~v[7], v[7], narrow}, rd);
            expSticky |= ill(expLvl, narrow);
            if (v[7])
               {expLvl, expLast, expPrev} = 5'h0;
            repeat (2) op(2'h0, 2'h0);
            ahb(1'b0, 12'h000, 32'h0000_0000, rd);
            check(rd, {31'h0, narrow});
         end
         for (i = 0; i < 1 + v[10:8]; i++) begin
            w = $random(seed);
            if (s == 0 && i == 0)
               w[3:0] = 4'h4;
            if (w[3:2] == 2'h2 && i != 0)
               w[3:2] = 2'h3;
            op(w[1:0], w[3:2]);
         end
         // corner: a flush followed by a quiet stretch
         if (s % 4 == 1)
            op(2'h0, 2'h2);
         repeat (5) op(2'h0, 2'h0);
         repeat (6) op(2'h1, 2'h0);
         check(32'({queue_fill_event, queueFillN, analyzer_ctrl_line2}), 32'h0000_0005);
         check(32'({analyzer_ctrl_line1, analyzer_ctrl_line0}), 32'({expPrev, expLast}));
         repeat (8) op(2'h0, 2'h0);
         check(32'({levelOutN, last_byte_first_n, prev_byte_first_n}),
               32'({~expLvl, ~expLast, ~expPrev}));
         check(32'({analyzer_ctrl_line2, analyzer_ctrl_line1, analyzer_ctrl_line0}),
               32'({1'b0, mnioCmd, rnwCmd}));
         ahb(1'b0, 12'h004, 32'h0000_0000, rd);
         check(32'(rd[7:0]),
               32'({1'b0, expPrev, expLast, expSticky, ill(expLvl, narrow), expLvl}));
      end
      close_out();
   end
   // cut a hang short well after the expected run length
   initial begin
      #60000;
      miscompares++;
      close_out();
   end
endmodule // testbench
`default_nettype wire
